// ### rtl/pa_level_table_and_wake.sv
// Power table, chip select wake and sleep, calibration and lock indication.
`timescale 1ns/100ps
module pa_level_table_and_wake
  import pa_pkg::*;
#(
  parameter int CAL_CYCLES  = pa_pkg::CAL_CYCLES,
  parameter int WAKE_CYCLES = pa_pkg::WAKE_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       chipSelectLow_n,
  input  wire logic       spiClk,
  input  wire logic       spiMosi,
  output logic            spiMiso,
  output logic            spiMisoOe,
  input  wire logic       powerTableIndex,
  input  wire logic [5:0] outputPinSignalSelect0,
  input  wire logic [5:0] outputPinSignalSelect1,
  input  wire logic [5:0] outputPinSignalSelect2,
  input  wire logic [5:0] vcoCalCode,
  input  wire logic       pllLockRaw,
  output logic [2:0]      generalOutputPin,
  output logic [7:0]      paLevel,
  output logic [5:0]      synthCalResult,
  output logic            lockDetected,
  output logic            coreSupplyOn,
  output logic            oscRun
);
  import pa_pkg::*;

  localparam int TIMER_W = $clog2((CAL_CYCLES > WAKE_CYCLES ? CAL_CYCLES : WAKE_CYCLES) + 1);
  localparam logic [TIMER_W-1:0] CAL_LAST  = TIMER_W'(CAL_CYCLES - 1);
  localparam logic [TIMER_W-1:0] WAKE_LAST = TIMER_W'(WAKE_CYCLES - 1);

  // ************************************************************
  // Serial link side, clocked by the host's serial clock.
  // ************************************************************

  logic       frameRst_n;
  logic [6:0] shiftReg;
  logic [2:0] bitCount;
  logic [1:0] byteCount;
  logic       isBurst;
  logic       isRead;
  logic       isTable;
  logic [7:0] xferData;
  xfer_slot_t xferSlot;
  logic       xferToggle;
  logic [6:0] next_shiftReg;
  logic [2:0] next_bitCount;
  logic [1:0] next_byteCount;
  logic       next_isBurst;
  logic       next_isRead;
  logic       next_isTable;
  logic [7:0] next_xferData;
  xfer_slot_t next_xferSlot;
  logic       next_xferToggle;
  logic [7:0] fullByte;

  // A deselected link holds the frame logic in reset, so every frame starts clean.
  assign frameRst_n = arst_n & ~chipSelectLow_n;
  assign fullByte   = {shiftReg, spiMosi};

  always_comb
  begin
    next_shiftReg   = {shiftReg[5:0], spiMosi};
    next_bitCount   = bitCount + 3'h1;
    next_byteCount  = byteCount;
    next_isBurst    = isBurst;
    next_isRead     = isRead;
    next_isTable    = isTable;
    next_xferData   = xferData;
    next_xferSlot   = xferSlot;
    next_xferToggle = xferToggle;
    if (bitCount == 3'h7)
    begin
      next_xferData   = fullByte;
      next_xferToggle = ~xferToggle;
      if (byteCount != 2'h3)
      begin
        next_byteCount = byteCount + 2'h1;
      end
      if (byteCount == 2'h0)
      begin
        next_xferSlot = SLOT_HEADER;
        next_isBurst  = fullByte[HDR_BURST_BIT];
        next_isRead   = fullByte[HDR_READ_BIT];
        next_isTable  = (fullByte[5:0] == TABLE_ADDR);
      end
      else if (isRead || !isTable)
      begin
        next_xferSlot = SLOT_IGNORE;
      end
      else if (byteCount == 2'h1)
      begin
        next_xferSlot = SLOT_ENTRY0;
      end
      else if (byteCount == 2'h2 && isBurst)
      begin
        next_xferSlot = SLOT_ENTRY1;
      end
      else
      begin
        next_xferSlot = SLOT_IGNORE;
      end
    end
  end

  always_ff @(posedge spiClk or negedge frameRst_n)
  begin
    if (!frameRst_n)
    begin
      shiftReg  <= 7'h00;
      bitCount  <= 3'h0;
      byteCount <= 2'h0;
      isBurst   <= 1'b0;
      isRead    <= 1'b0;
      isTable   <= 1'b0;
    end
    else
    begin
      shiftReg  <= next_shiftReg;
      bitCount  <= next_bitCount;
      byteCount <= next_byteCount;
      isBurst   <= next_isBurst;
      isRead    <= next_isRead;
      isTable   <= next_isTable;
    end
  end

  // The handed-over byte keeps its value across frames so the toggle never fires falsely.
  always_ff @(posedge spiClk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      xferData   <= 8'h00;
      xferSlot   <= SLOT_IGNORE;
      xferToggle <= 1'b0;
    end
    else
    begin
      xferData   <= next_xferData;
      xferSlot   <= next_xferSlot;
      xferToggle <= next_xferToggle;
    end
  end

  // ************************************************************
  // Crossing into the core clock domain.
  // ************************************************************

  logic       csSync_n;
  logic       togSync;
  logic       lockSync;
  logic [5:0] codeSync;
  logic       csPrev_n;
  logic       togPrev;
  logic       csFall;
  logic       csRise;
  logic       byteEvt;

  sync_two_flop #(
    .WIDTH   (9),
    .RST_VAL (9'h100)
  ) u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .d      ({chipSelectLow_n, xferToggle, pllLockRaw, vcoCalCode}),
    .q      ({csSync_n, togSync, lockSync, codeSync})
  );

  assign csFall  = csPrev_n & ~csSync_n;
  assign csRise  = ~csPrev_n & csSync_n;
  assign byteEvt = togSync ^ togPrev;

  // ************************************************************
  // Power state, calibration and power table.
  // ************************************************************

  power_state_t       state;
  power_state_t       next_state;
  logic [TIMER_W-1:0] timer;
  logic [TIMER_W-1:0] next_timer;
  logic [7:0]         powerTable0;
  logic [7:0]         powerTable1;
  logic [7:0]         next_powerTable0;
  logic [7:0]         next_powerTable1;
  logic [5:0]         next_synthCalResult;
  logic               hdrEvt;
  logic               calEvt;
  logic               pdEvt;

  assign hdrEvt = byteEvt && (xferSlot == SLOT_HEADER);
  assign calEvt = hdrEvt && (xferData[5:0] == CAL_STROBE_ADDR);
  assign pdEvt  = hdrEvt && (xferData[5:0] == PD_STROBE_ADDR);

  always_comb
  begin
    next_state          = state;
    next_timer          = timer;
    next_powerTable0    = powerTable0;
    next_powerTable1    = powerTable1;
    next_synthCalResult = synthCalResult;
    unique case (state)
      ST_AWAKE:
      begin
        if (pdEvt)
        begin
          next_state = ST_PD_PEND;
        end
        else if (calEvt)
        begin
          next_state = ST_CALIB;
          next_timer = '0;
        end
        else if (byteEvt && xferSlot == SLOT_ENTRY0)
        begin
          next_powerTable0 = xferData;
        end
        else if (byteEvt && xferSlot == SLOT_ENTRY1)
        begin
          next_powerTable1 = xferData;
        end
      end
      ST_CALIB:
      begin
        next_timer = timer + 1'b1;
        if (timer == CAL_LAST)
        begin
          next_state          = ST_AWAKE;
          next_synthCalResult = lockSync ? codeSync : CAL_UNLOCKED;
        end
      end
      ST_PD_PEND:
      begin
        if (csRise)
        begin
          next_state       = ST_ASLEEP;
          next_powerTable1 = ENTRY_CLEARED;
        end
      end
      ST_ASLEEP:
      begin
        if (csFall)
        begin
          next_state = ST_WAKING;
          next_timer = '0;
        end
      end
      ST_WAKING:
      begin
        next_timer = timer + 1'b1;
        if (timer == WAKE_LAST)
        begin
          next_state = ST_AWAKE;
        end
      end
      default:
      begin
        next_state = ST_AWAKE;
      end
    endcase
  end

  // The calibration result is held in sleep and only changes at the end of a calibration.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state          <= ST_AWAKE;
      timer          <= '0;
      powerTable0    <= PA_LEVEL_RESET;
      powerTable1    <= ENTRY_CLEARED;
      synthCalResult <= CAL_UNLOCKED;
      csPrev_n       <= 1'b1;
      togPrev        <= 1'b0;
    end
    else
    begin
      state          <= next_state;
      timer          <= next_timer;
      powerTable0    <= next_powerTable0;
      powerTable1    <= next_powerTable1;
      synthCalResult <= next_synthCalResult;
      csPrev_n       <= csSync_n;
      togPrev        <= togSync;
    end
  end

  // ************************************************************
  // Registered outputs.
  // ************************************************************

  function automatic logic pinLevel(input logic [5:0] sel, input logic asleep,
                                    input logic lock, input logic idleHigh);
    if (asleep && sel < PIN_SLEEP_LIMIT)
    begin
      return idleHigh;
    end
    else if (sel == PIN_SEL_LOCK)
    begin
      return lock;
    end
    return 1'b0;
  endfunction

  logic [5:0] pinSel [3];
  logic [2:0] next_generalOutputPin;
  logic [7:0] next_paLevel;
  logic       next_lockDetected;
  logic       next_coreSupplyOn;
  logic       next_spiMiso;
  logic       next_spiMisoOe;
  logic       nextAsleep;
  logic [7:0] selLevel;

  assign pinSel[0]  = outputPinSignalSelect0;
  assign pinSel[1]  = outputPinSignalSelect1;
  assign pinSel[2]  = outputPinSignalSelect2;
  assign selLevel   = powerTableIndex ? powerTable1 : powerTable0;
  assign nextAsleep = (next_state == ST_ASLEEP);

  always_comb
  begin
    next_paLevel      = selLevel;
    next_lockDetected = (next_synthCalResult != CAL_UNLOCKED);
    next_coreSupplyOn = ~nextAsleep;
    next_spiMisoOe    = ~csSync_n;
    next_spiMiso      = ~(next_state == ST_AWAKE || next_state == ST_CALIB
                          || next_state == ST_PD_PEND);
    for (int i = 0; i < 3; i++)
    begin
      next_generalOutputPin[i] = pinLevel(pinSel[i], nextAsleep, next_lockDetected,
                                          i == 1);
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      paLevel          <= PA_LEVEL_RESET;
      lockDetected     <= 1'b0;
      coreSupplyOn     <= 1'b1;
      oscRun           <= 1'b1;
      spiMiso          <= 1'b1;
      spiMisoOe        <= 1'b0;
      generalOutputPin <= 3'h0;
    end
    else
    begin
      paLevel          <= next_paLevel;
      lockDetected     <= next_lockDetected;
      coreSupplyOn     <= next_coreSupplyOn;
      oscRun           <= next_coreSupplyOn;
      spiMiso          <= next_spiMiso;
      spiMisoOe        <= next_spiMisoOe;
      generalOutputPin <= next_generalOutputPin;
    end
  end

  // ************************************************************
  // Assertions and covers.
  // ************************************************************

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_pd_waits_cs: assert property ((state == ST_PD_PEND && !csRise) |=> state != ST_ASLEEP)
    else $error("Sleep entered without chip select rising.");

  a_sleep_on_rise: assert property ((state == ST_PD_PEND && csRise)
                                    |=> state == ST_ASLEEP ##1 !coreSupplyOn && !oscRun)
    else $error("Power not removed after chip select rose.");

  a_wake_on_fall: assert property ((state == ST_ASLEEP && csFall)
                                   |=> state == ST_WAKING ##1 coreSupplyOn && oscRun)
    else $error("Chip select fall did not wake the core.");

  a_miso_ready: assert property ((state == ST_WAKING && timer == WAKE_LAST)
                                 |=> ##1 !spiMiso)
    else $error("Data output not pulled low when ready.");

  a_cal_kept: assert property ((state == ST_ASLEEP) |=> $stable(synthCalResult))
    else $error("Calibration result changed in sleep.");

  a_table_sleep: assert property ((state == ST_ASLEEP && $past(state) == ST_ASLEEP)
                                  |-> $stable(powerTable0) && powerTable1 == ENTRY_CLEARED)
    else $error("Power table not kept or cleared in sleep.");

  a_lock_value: assert property (##1 lockDetected == (synthCalResult != CAL_UNLOCKED))
    else $error("Lock flag disagrees with calibration result.");

  a_pa_select: assert property (##1 paLevel == $past(selLevel))
    else $error("Power level does not follow the table index.");

  a_pin_lock: assert property ((outputPinSignalSelect0 == PIN_SEL_LOCK && !nextAsleep)
                               |=> generalOutputPin[0] == lockDetected)
    else $error("Lock pin does not show lock status.");

  a_pin_sleep: assert property (nextAsleep && outputPinSignalSelect1 < PIN_SLEEP_LIMIT
                                |=> generalOutputPin[1])
    else $error("Sleeping pin not forced to its fixed level.");

  a_cal_start: assert property ((state == ST_AWAKE && calEvt && !pdEvt)
                                |=> state == ST_CALIB)
    else $error("Calibrate strobe did not start calibration.");

  c_sleep: cover property (state == ST_PD_PEND ##1 state == ST_ASLEEP);
  c_wake: cover property (state == ST_WAKING ##1 state == ST_AWAKE);
  c_cal_lock: cover property (state == ST_CALIB ##1 state == ST_AWAKE && lockDetected);
  c_entry1: cover property (byteEvt && xferSlot == SLOT_ENTRY1 && state == ST_AWAKE);

endmodule

// ### rtl/pa_pkg.sv
// Constants and types for the power table, wake and lock block.
// What this block does
// - Calibration result survives the sleep state.
// - Lock code on pin drives lock status.
// - Result other than all ones means locked.
// - Chip select low powers core, starts oscillator.
// - Data output low signals ready; host waits.
// - Power-down takes effect when chip select rises.
// - Chip select falling edge wakes from power-down.
// - Two table entries; index picks one.
// - Entry one reachable only by burst write.
// - Sleep keeps entry zero, clears entry one.
// - Entry zero resets to 0xC6.
// - Calibrate strobe in idle starts calibration.
// - Sleep forces pins with select below 0x20.
package pa_pkg;

  localparam int CLK_MHZ          = 50;
  localparam int OSC_START_US     = 20;
  localparam int WAKE_CYCLES      = OSC_START_US * CLK_MHZ;
  localparam int CAL_TIME_US      = 145;
  localparam int CAL_CYCLES       = CAL_TIME_US * CLK_MHZ;

  localparam int HDR_READ_BIT     = 7;
  localparam int HDR_BURST_BIT    = 6;
  localparam logic [5:0] TABLE_ADDR      = 6'h3E;
  localparam logic [5:0] CAL_STROBE_ADDR = 6'h33;
  localparam logic [5:0] PD_STROBE_ADDR  = 6'h39;

  localparam logic [7:0] PA_LEVEL_RESET  = 8'hC6;
  localparam logic [7:0] ENTRY_CLEARED   = 8'h00;
  localparam logic [5:0] CAL_UNLOCKED    = 6'h3F;
  localparam logic [5:0] PIN_SEL_LOCK    = 6'h0A;
  localparam logic [5:0] PIN_SLEEP_LIMIT = 6'h20;
  localparam logic [5:0] PIN_SEL_RESET   = 6'h00;

  typedef enum logic [1:0] {
    SLOT_HEADER = 2'h0,
    SLOT_ENTRY0 = 2'h1,
    SLOT_ENTRY1 = 2'h2,
    SLOT_IGNORE = 2'h3
  } xfer_slot_t;

  typedef enum logic [4:0] {
    ST_AWAKE   = 5'h01,
    ST_CALIB   = 5'h02,
    ST_PD_PEND = 5'h04,
    ST_ASLEEP  = 5'h08,
    ST_WAKING  = 5'h10
  } power_state_t;

endpackage

// ### rtl/sync_two_flop.sv
// Two flip-flop synchroniser for slow levels entering the core clock domain.
`timescale 1ns/100ps
module sync_two_flop #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] stage;

  // Each line resets to its idle level, so no false edge follows reset.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stage <= RST_VAL;
      q     <= RST_VAL;
    end
    else
    begin
      stage <= d;
      q     <= stage;
    end
  end

endmodule

// ### sim/host_model.sv
// Host microcontroller model that drives the serial link of the block.
`timescale 1ns/100ps
module host_model (
  input  wire logic clk,
  input  wire logic spiMiso,
  input  wire logic spiMisoOe,
  output logic      chipSelectLow_n,
  output logic      spiClk,
  output logic      spiMosi,
  output logic      timedOut
);
  initial
  begin
    chipSelectLow_n = 1'b1;
    spiClk = 1'b0;
    spiMosi = 1'b0;
    timedOut = 1'b0;
  end

  // **********************************************************************
  // Frame tasks.
  // **********************************************************************
  task automatic release_cs();
    chipSelectLow_n = 1'b1;
    spiMosi = ~spiMosi;
  endtask

  task automatic frame(input logic [23:0] bytes, input int count, input bit keepLow);
    int n;
    n = 0;
    chipSelectLow_n = 1'b0;
    while (!(spiMisoOe === 1'b1 && spiMiso === 1'b0) && n < 2000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 2000)
      timedOut = 1'b1;
    #3;
    for (int b = 23; b > 23 - 8 * count; b--)
    begin
      spiMosi = bytes[b];
      #7.5 spiClk = 1'b1;
      #7.5 spiClk = 1'b0;
    end
    spiMosi = ~spiMosi;
    repeat (6) @(negedge clk);
    if (!keepLow)
      release_cs();
  endtask
endmodule

// ### sim/testbench.sv
// Self-checking testbench for the power table, wake and lock block.
`timescale 1ns/100ps
module testbench;
  import pa_pkg::*;
  localparam int CAL_N  = 20;
  localparam int WAKE_N = 10;
  logic        clk;
  logic        arst_n;
  logic        chipSelectLow_n;
  logic        spiClk;
  logic        spiMosi;
  logic        spiMiso;
  logic        spiMisoOe;
  logic        powerTableIndex;
  logic [5:0]  pinSel [3];
  logic [5:0]  vcoCalCode;
  logic        pllLockRaw;
  logic [2:0]  generalOutputPin;
  logic [7:0]  paLevel;
  logic [5:0]  synthCalResult;
  logic        lockDetected;
  logic        coreSupplyOn;
  logic        oscRun;
  logic        timedOut;
  logic [31:0] seed;
  logic [7:0]  e0;
  logic [7:0]  e1;
  logic [5:0]  calExp;
  int          n_fail;
  int          num_checks;
  int          tries;

  pa_level_table_and_wake #(.CAL_CYCLES(CAL_N), .WAKE_CYCLES(WAKE_N))
    pa_level_table_and_wake_inst (
    .clk(clk), .arst_n(arst_n), .chipSelectLow_n(chipSelectLow_n), .spiClk(spiClk),
    .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe),
    .powerTableIndex(powerTableIndex), .outputPinSignalSelect0(pinSel[0]),
    .outputPinSignalSelect1(pinSel[1]), .outputPinSignalSelect2(pinSel[2]),
    .vcoCalCode(vcoCalCode), .pllLockRaw(pllLockRaw), .generalOutputPin(generalOutputPin),
    .paLevel(paLevel), .synthCalResult(synthCalResult), .lockDetected(lockDetected),
    .coreSupplyOn(coreSupplyOn), .oscRun(oscRun));

  host_model host_model_inst (
    .clk(clk), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe), .chipSelectLow_n(chipSelectLow_n),
    .spiClk(spiClk), .spiMosi(spiMosi), .timedOut(timedOut));

  // **********************************************************************
  // Expectations and helpers.
  // **********************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] next_level();
    do
      seed = lfsr(seed);
    while (seed[7:0] >= 8'h61 && seed[7:0] <= 8'h6F);
    return seed[7:0];
  endfunction

  function automatic logic [5:0] exp_cal(input logic lock, input logic [5:0] code);
    return lock ? code : 6'h3F;
  endfunction

  function automatic logic exp_pin(input logic [5:0] sel, input logic lock,
                                   input logic asleep, input int pin);
    if (asleep && sel < 6'h20)
      return (pin == 1);
    return (sel == 6'h0A) ? lock : 1'b0;
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expv);
    num_checks++;
    if (seen !== expv)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, expv, seen);
    end
  endtask

  task automatic check_pins(input logic asleep, input logic lock);
    for (int i = 0; i < 3; i++)
      check("pin", {7'h00, generalOutputPin[i]},
            {7'h00, exp_pin(pinSel[i], lock, asleep, i)});
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // **********************************************************************
  // Clock, watchdog and main sequence.
  // **********************************************************************
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    repeat (20000)
    begin
      @(posedge clk);
      if (timedOut === 1'b1)
        break;
    end
    n_fail++;
    tally_and_finish();
  end

  initial
  begin
    arst_n = 1'b0;
    powerTableIndex = 1'b0;
    pinSel = '{6'h0A, 6'h20, 6'h05};
    vcoCalCode = 6'h00;
    pllLockRaw = 1'b0;
    seed = 32'h0001277B;
    n_fail = 0;
    num_checks = 0;
    settle(10);
    arst_n = 1'b1;
    settle(1);
    check("paLevel", paLevel, PA_LEVEL_RESET);
    check("calResult", {2'h0, synthCalResult}, 8'h3F);
    check("lock", {7'h00, lockDetected}, 8'h00);
    check("supply", {7'h00, coreSupplyOn}, 8'h01);
    check("miso", {7'h00, spiMiso}, 8'h00);
    check("misoOe", {7'h00, spiMisoOe}, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      e0 = next_level();
      e1 = next_level();
      host_model_inst.frame({8'h7E, e0, e1}, 3, 1'b0);
      settle(6);
      for (int i = 0; i < 2; i++)
      begin
        powerTableIndex = i[0];
        settle(3);
        check("paLevel", paLevel, i[0] ? e1 : e0);
      end
    end
    e0 = next_level();
    host_model_inst.frame({8'h3E, e0, 8'h11}, 3, 1'b0);
    settle(6);
    check("paLevel", paLevel, e1);
    powerTableIndex = 1'b0;
    settle(3);
    check("paLevel", paLevel, e0);
    tries = 0;
    do
    begin
      pllLockRaw = (tries > 0);
      seed = lfsr(seed);
      vcoCalCode = (seed[5:0] == 6'h3F) ? 6'h15 : seed[5:0];
      calExp = exp_cal(pllLockRaw, vcoCalCode);
      host_model_inst.frame({8'h33, 16'h0000}, 1, 1'b0);
      settle(CAL_N + 8);
      check("calResult", {2'h0, synthCalResult}, {2'h0, calExp});
      check("lock", {7'h00, lockDetected}, {7'h00, pllLockRaw});
      check_pins(1'b0, pllLockRaw);
      tries++;
    end
    while (lockDetected !== 1'b1 && tries < 3);
    host_model_inst.frame({8'h39, 16'h0000}, 1, 1'b1);
    settle(8);
    check("supply", {7'h00, coreSupplyOn}, 8'h01);
    host_model_inst.release_cs();
    pinSel[1] = 6'h0A;
    settle(6);
    vcoCalCode = ~vcoCalCode;
    check("miso", {7'h00, spiMiso}, 8'h01);
    check("supply", {7'h00, coreSupplyOn}, 8'h00);
    check("osc", {7'h00, oscRun}, 8'h00);
    check_pins(1'b1, 1'b1);
    host_model_inst.frame({8'h3E, 16'h0000}, 1, 1'b0);
    settle(2);
    check("supply", {7'h00, coreSupplyOn}, 8'h01);
    check("osc", {7'h00, oscRun}, 8'h01);
    check("calResult", {2'h0, synthCalResult}, {2'h0, calExp});
    check("paLevel", paLevel, e0);
    powerTableIndex = 1'b1;
    settle(3);
    check("paLevel", paLevel, ENTRY_CLEARED);
    tally_and_finish();
  end
endmodule
